/* File: testbench/lbdc_loop_config_properties.sv */
// bound checker for the loop configuration register bank
`timescale 1ns/10ps
module lbdc_loop_config_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic       reg_hit_q,
   input wire logic       primary_analog_fb,
   input wire logic       primary_ref_lowrate,
   input wire logic       primary_auto_gain_en,
   input wire logic       secondary_analog_fb,
   input wire logic       secondary_ref_lowrate,
   input wire logic       secondary_auto_gain_en,
   input wire logic [7:0] primary_damp_x10_q,
   input wire logic [5:0] primary_peak_cdb_q,
   input wire logic [2:0] primary_lowrate_analog_gain_q,
   input wire logic       primary_gain_apply_q,
   input wire logic [7:0] secondary_damp_x10_q,
   input wire logic [5:0] secondary_peak_cdb_q,
   input wire logic       secondary_gain_apply_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic mapped, pri_wr;
   // address decode and primary damping write strobe
   assign mapped = reg_addr inside {7'h67, 7'h69, 7'h6A, 7'h6B};
   assign pri_wr = reg_wr && reg_addr == lbdc_pkg::ADDR_PRI_DAMPING;
   // gain peak expected for a damping factor
   function automatic logic [5:0] peak_of(input logic [7:0] d);
      case (d)
         8'h0C: return 6'h28;
         8'h19: return 6'h14;
         8'h32: return 6'h0A;
         8'h64: return 6'h06;
         8'hC8: return 6'h03;
         default: return 6'h00;
      endcase
   endfunction
   sequence pri_wr_seen;
      pri_wr ##1 1'b1;
   endsequence
   a_unmapped_read_zero: assert property (reg_rd && !mapped |=> !reg_hit_q && reg_rdata_q == 8'h00)
      else $error("unmapped read not refused");
   a_mapped_read_hit: assert property (reg_rd && mapped |=> reg_hit_q)
      else $error("mapped read missed");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q) && $stable(reg_hit_q))
      else $error("read data moved without read");
   a_pri_gain_apply: assert property (1'b1 |=> primary_gain_apply_q ==
      $past(primary_analog_fb && primary_ref_lowrate && primary_auto_gain_en))
      else $error("primary gain apply wrong");
   a_sec_gain_apply: assert property (1'b1 |=> secondary_gain_apply_q ==
      $past(secondary_analog_fb && secondary_ref_lowrate && secondary_auto_gain_en))
      else $error("secondary gain apply wrong");
   a_pri_peak_match: assert property (primary_peak_cdb_q == peak_of(primary_damp_x10_q))
      else $error("primary gain peak wrong");
   a_sec_peak_match: assert property (secondary_peak_cdb_q == peak_of(secondary_damp_x10_q))
      else $error("secondary gain peak wrong");
   a_pri_gain_load: assert property (pri_wr_seen |=>
      primary_lowrate_analog_gain_q == $past(reg_wdata[6:4], 2))
      else $error("primary gain field not loaded");
endmodule
bind lbdc_loop_config lbdc_loop_config_chk u_lbdc_loop_config_chk (.mclk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .reg_hit_q, .primary_analog_fb,
   .primary_ref_lowrate, .primary_auto_gain_en, .secondary_analog_fb, .secondary_ref_lowrate,
   .secondary_auto_gain_en, .primary_damp_x10_q, .primary_peak_cdb_q,
   .primary_lowrate_analog_gain_q, .primary_gain_apply_q, .secondary_damp_x10_q,
   .secondary_peak_cdb_q, .secondary_gain_apply_q);

/* File: testbench/lbdc_loop_config_test.sv */
// self-checking bench for the loop configuration register bank
`timescale 1ns/10ps
module lbdc_loop_config_test;
   logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, d, e;
   logic [1:0] ctl = 2'h1, sbw = 2'h0, lb, ab;
   logic [5:0] gc = 6'h00;
   logic [7:0] rdv, pdx, sdx;
   logic [5:0] ppk, spk;
   logic [2:0] pdf, pgn, sdf, sgn;
   logic [1:0] pbw;
   logic rhit, pap, sap;
   int mismatches = 0, n_compared = 0, seed = 38;
   lbdc_loop_config u_lbdc_loop_config (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q(rdv), .reg_hit_q(rhit), .auto_bw_switch_en(ctl[0]),
      .primary_phase_locked(ctl[1]), .secondary_bw(sbw), .primary_analog_fb(gc[0]),
      .primary_ref_lowrate(gc[1]), .primary_auto_gain_en(gc[2]), .secondary_analog_fb(gc[3]),
      .secondary_ref_lowrate(gc[4]), .secondary_auto_gain_en(gc[5]), .primary_bw_q(pbw),
      .primary_damping_field_q(pdf), .primary_damp_x10_q(pdx), .primary_peak_cdb_q(ppk),
      .primary_lowrate_analog_gain_q(pgn), .primary_gain_apply_q(pap),
      .secondary_damping_field_q(sdf), .secondary_damp_x10_q(sdx), .secondary_peak_cdb_q(spk),
      .secondary_lowrate_analog_gain_q(sgn), .secondary_gain_apply_q(sap));
   // clock
   always #10 mclk = ~mclk;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] v, input logic hv);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 cmp(rdv, v);
      cmp({7'h00, rhit}, {7'h00, hv});
   endtask
   // register image and loop fields after a reset release
   task automatic chk_reset;
      rchk(7'h67, 8'h10, 1'b1);
      rchk(7'h69, 8'h11, 1'b1);
      rchk(7'h6A, 8'h13, 1'b1);
      rchk(7'h6B, 8'h13, 1'b1);
      rchk(7'h68, 8'h00, 1'b0);
      cmp({5'h00, pdf}, 8'h03);
      cmp({5'h00, sdf}, 8'h03);
      cmp({5'h00, pgn}, 8'h01);
   endtask
   // damping factor in tenths for bandwidth code and damping code
   function automatic logic [7:0] df(input logic [1:0] bw, input logic [2:0] c);
      case (c)
         3'h1: return 8'h0C;
         3'h2: return 8'h19;
         3'h3: return 8'h32;
         3'h4: return (bw == 2'h1 || bw == 2'h2) ? 8'h64 : 8'h32;
         3'h5: return bw == 2'h1 ? 8'h64 : (bw == 2'h2 ? 8'hC8 : 8'h32);
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] pk(input logic [7:0] f);
      case (f)
         8'h0C: return 8'h28;
         8'h19: return 8'h14;
         8'h32: return 8'h0A;
         8'h64: return 8'h06;
         8'hC8: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chk_reset();
      // damping sweep on the secondary loop over every column and code
      for (int i = 0; i < 24; i++) begin
         @(posedge mclk);
         sbw <= i[4:3];
         d = $random(seed);
         d[2:0] = i[2:0];
         wr(7'h6A, d);
         @(posedge mclk);
         #1 cmp(sdx, df(sbw, d[2:0]));
         cmp(spk, pk(df(sbw, d[2:0])));
         cmp({5'h00, sgn}, {5'h00, d[6:4]});
         cmp({5'h00, sdf}, {5'h00, d[2:0]});
         rchk(7'h6A, d, 1'b1);
      end
      // bandwidth selection under each lock and switching state
      for (int i = 0; i < 8; i++) begin
         lb = $unsigned($random(seed)) % 3;
         ab = $unsigned($random(seed)) % 3;
         d = $random(seed);
         wr(7'h67, {6'h15, lb});
         wr(7'h69, {6'h2A, ab});
         wr(7'h6B, {d[7:3], 3'h5});
         @(posedge mclk);
         ctl <= i[1:0];
         repeat (2) @(posedge mclk);
         e = (ctl == 2'h1) ? ab : lb;
         #1 cmp({6'h00, pbw}, e);
         cmp(pdx, df(e[1:0], 3'h5));
         cmp({5'h00, pgn}, {5'h00, d[6:4]});
         cmp({5'h00, pdf}, 8'h05);
      end
      // gain apply needs analog feedback, low-rate reference and auto gain
      for (int i = 0; i < 16; i++) begin
         @(posedge mclk);
         gc <= (i == 0) ? 6'h3F : 6'($random(seed));
         @(posedge mclk);
         #1 cmp({7'h00, pap}, {7'h00, &gc[2:0]});
         cmp({7'h00, sap}, {7'h00, &gc[5:3]});
      end
      // mid-run reset brings back the register image and the three field reset values
      @(posedge mclk);
      gc    <= 6'h00;
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chk_reset();
      summarize();
   end
endmodule

/* File: verilog/lbdc_damp_decode.sv */
// damping code and bandwidth to damping factor and gain peak
`timescale 1ns/10ps
module lbdc_damp_decode (
   input  wire logic [1:0] bw,
   input  wire logic [2:0] code,
   output logic      [7:0] damp_x10,
   output logic      [5:0] peak_cdb
);
   // damping table, columns by bandwidth
   always_comb begin
      damp_x10 = lbdc_pkg::DF_NONE;
      case (code)
         lbdc_pkg::DAMP_C1: damp_x10 = lbdc_pkg::DF_1P2;
         lbdc_pkg::DAMP_C2: damp_x10 = lbdc_pkg::DF_2P5;
         lbdc_pkg::DAMP_C3: damp_x10 = lbdc_pkg::DF_5;
         lbdc_pkg::DAMP_C4: begin
            damp_x10 = (bw == lbdc_pkg::BW_35HZ || bw == lbdc_pkg::BW_70HZ) ?
                       lbdc_pkg::DF_10 : lbdc_pkg::DF_5;
         end
         lbdc_pkg::DAMP_C5: begin
            if (bw == lbdc_pkg::BW_70HZ) begin
               damp_x10 = lbdc_pkg::DF_20;
            end else if (bw == lbdc_pkg::BW_35HZ) begin
               damp_x10 = lbdc_pkg::DF_10;
            end else begin
               damp_x10 = lbdc_pkg::DF_5;
            end
         end
         default: damp_x10 = lbdc_pkg::DF_NONE;
      endcase
   end

   // gain peak follows the damping factor
   always_comb begin
      case (damp_x10)
         lbdc_pkg::DF_1P2: peak_cdb = lbdc_pkg::GP_0P4;
         lbdc_pkg::DF_2P5: peak_cdb = lbdc_pkg::GP_0P2;
         lbdc_pkg::DF_5:   peak_cdb = lbdc_pkg::GP_0P1;
         lbdc_pkg::DF_10:  peak_cdb = lbdc_pkg::GP_0P06;
         lbdc_pkg::DF_20:  peak_cdb = lbdc_pkg::GP_0P03;
         default:          peak_cdb = lbdc_pkg::GP_NONE;
      endcase
   end
endmodule

/* File: verilog/lbdc_loop_config.sv */
// loop bandwidth and damping configuration registers for two loops
//
// Contract
// - primary loop holds two-bit locked bandwidth, used always or after lock.
// - primary acquisition bandwidth in low two bits, used while acquiring lock.
// - three-bit damping code picks damping factor per 18/35/70 Hz bandwidth.
// - analog gain field drives second detector only for low-rate analog auto mode.
// - gain peak follows damping: 0.4, 0.2, 0.1, 0.06, 0.03 dB.
`timescale 1ns/10ps
module lbdc_loop_config (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // decoded serial configuration port access
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata_q,
   output logic            reg_hit_q,
   // loop state and control from the rest of the device
   input  wire logic       auto_bw_switch_en,
   input  wire logic       primary_phase_locked,
   input  wire logic [1:0] secondary_bw,
   input  wire logic       primary_analog_fb,
   input  wire logic       primary_ref_lowrate,
   input  wire logic       primary_auto_gain_en,
   input  wire logic       secondary_analog_fb,
   input  wire logic       secondary_ref_lowrate,
   input  wire logic       secondary_auto_gain_en,
   // applied loop settings
   output logic      [1:0] primary_bw_q,
   output logic      [2:0] primary_damping_field_q,
   output logic      [7:0] primary_damp_x10_q,
   output logic      [5:0] primary_peak_cdb_q,
   output logic      [2:0] primary_lowrate_analog_gain_q,
   output logic            primary_gain_apply_q,
   output logic      [2:0] secondary_damping_field_q,
   output logic      [7:0] secondary_damp_x10_q,
   output logic      [5:0] secondary_peak_cdb_q,
   output logic      [2:0] secondary_lowrate_analog_gain_q,
   output logic            secondary_gain_apply_q
);
   logic [7:0] locked_bw_q;
   logic [7:0] locked_bw_d;
   logic [7:0] acq_bw_q;
   logic [7:0] acq_bw_d;
   logic [7:0] pri_damp_q;
   logic [7:0] pri_damp_d;
   logic [7:0] sec_damp_q;
   logic [7:0] sec_damp_d;
   logic [7:0] rdata_d;
   logic       hit_d;
   logic [1:0] pri_bw_d;
   logic [7:0] pri_df;
   logic [5:0] pri_gp;
   logic [7:0] sec_df;
   logic [5:0] sec_gp;
   logic       pri_apply_d;
   logic       sec_apply_d;
   // next values of the per-loop field outputs
   logic [2:0] pri_field_d;
   logic [2:0] pri_gain_d;
   logic [2:0] sec_field_d;
   logic [2:0] sec_gain_d;
   // decode signals, primary loop in slot 0 and secondary in slot 1
   localparam int N_LOOPS = 2;
   logic [1:0] loop_bw   [N_LOOPS];
   logic [2:0] loop_code [N_LOOPS];
   logic [7:0] loop_df   [N_LOOPS];
   logic [5:0] loop_gp   [N_LOOPS];

   // register writes, all eight bits kept so software reads back
   // exactly what it wrote, unused bits included
   always_comb begin
      locked_bw_d = locked_bw_q;
      acq_bw_d    = acq_bw_q;
      pri_damp_d  = pri_damp_q;
      sec_damp_d  = sec_damp_q;
      if (reg_wr) begin
         case (reg_addr)
            lbdc_pkg::ADDR_PRI_LOCKED_BW: locked_bw_d = reg_wdata;
            lbdc_pkg::ADDR_PRI_ACQ_BW:    acq_bw_d    = reg_wdata;
            lbdc_pkg::ADDR_PRI_DAMPING:   pri_damp_d  = reg_wdata;
            lbdc_pkg::ADDR_SEC_DAMPING:   sec_damp_d  = reg_wdata;
            default:                      locked_bw_d = locked_bw_q;
         endcase
      end
   end

   // register reads, zero and no hit for unmapped addresses
   // a read in the same cycle as a write returns the old contents
   always_comb begin
      rdata_d = reg_rdata_q;
      hit_d   = reg_hit_q;
      if (reg_rd) begin
         hit_d = 1'b1;
         case (reg_addr)
            lbdc_pkg::ADDR_PRI_LOCKED_BW: rdata_d = locked_bw_q;
            lbdc_pkg::ADDR_PRI_ACQ_BW:    rdata_d = acq_bw_q;
            lbdc_pkg::ADDR_PRI_DAMPING:   rdata_d = pri_damp_q;
            lbdc_pkg::ADDR_SEC_DAMPING:   rdata_d = sec_damp_q;
            default: begin
               rdata_d = lbdc_pkg::RDATA_NONE;
               hit_d   = 1'b0;
            end
         endcase
      end
   end

   // active primary bandwidth: locked value always, or acquisition until lock
   // status inputs come from logic on mclk, so they need no synchroniser
   always_comb begin
      if (!auto_bw_switch_en || primary_phase_locked) begin
         pri_bw_d = locked_bw_q[lbdc_pkg::LOCKED_BW_MSB:0];
      end else begin
         pri_bw_d = acq_bw_q[lbdc_pkg::LOCKED_BW_MSB:0];
      end
   end

   // analog gain only for low-rate reference in analog feedback with auto gain
   // outside those conditions the field is stored but not in force
   always_comb begin
      pri_apply_d = primary_analog_fb && primary_ref_lowrate
                    && primary_auto_gain_en;
      sec_apply_d = secondary_analog_fb && secondary_ref_lowrate
                    && secondary_auto_gain_en;
   end

   // fields handed to the loops as they stand in the registers
   always_comb begin
      pri_field_d = pri_damp_q[lbdc_pkg::DAMP_MSB:0];
      pri_gain_d  = pri_damp_q[lbdc_pkg::GAIN_MSB:lbdc_pkg::GAIN_LSB];
      sec_field_d = sec_damp_q[lbdc_pkg::DAMP_MSB:0];
      sec_gain_d  = sec_damp_q[lbdc_pkg::GAIN_MSB:lbdc_pkg::GAIN_LSB];
   end

   // decode inputs and results per loop slot
   assign loop_bw[0]   = pri_bw_d;
   assign loop_bw[1]   = secondary_bw;
   assign loop_code[0] = pri_field_d;
   assign loop_code[1] = sec_field_d;
   assign pri_df       = loop_df[0];
   assign pri_gp       = loop_gp[0];
   assign sec_df       = loop_df[1];
   assign sec_gp       = loop_gp[1];

   // one damping decode per loop
   for (genvar g = 0; g < N_LOOPS; g++) begin : g_decode
      lbdc_damp_decode u_decode (
         .bw       (loop_bw[g]),
         .code     (loop_code[g]),
         .damp_x10 (loop_df[g]),
         .peak_cdb (loop_gp[g])
      );
   end

   // configuration register image
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         locked_bw_q <= lbdc_pkg::RST_PRI_LOCKED_BW;
         acq_bw_q    <= lbdc_pkg::RST_PRI_ACQ_BW;
         pri_damp_q  <= lbdc_pkg::RST_PRI_DAMPING;
         sec_damp_q  <= lbdc_pkg::RST_SEC_DAMPING;
      end else begin
         locked_bw_q <= locked_bw_d;
         acq_bw_q    <= acq_bw_d;
         pri_damp_q  <= pri_damp_d;
         sec_damp_q  <= sec_damp_d;
      end
   end

   // read port, holds its last answer until the next read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= lbdc_pkg::RDATA_NONE;
         reg_hit_q   <= 1'b0;
      end else begin
         reg_rdata_q <= rdata_d;
         reg_hit_q   <= hit_d;
      end
   end

   // primary loop settings, one edge behind the registers and status inputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primary_bw_q                  <= lbdc_pkg::BW_18HZ;
         primary_damping_field_q       <= lbdc_pkg::DAMP_C3;
         primary_damp_x10_q            <= lbdc_pkg::DF_5;
         primary_peak_cdb_q            <= lbdc_pkg::GP_0P1;
         primary_lowrate_analog_gain_q <=
            lbdc_pkg::RST_PRI_DAMPING[lbdc_pkg::GAIN_MSB:lbdc_pkg::GAIN_LSB];
         primary_gain_apply_q          <= 1'b0;
      end else begin
         primary_bw_q                  <= pri_bw_d;
         primary_damping_field_q       <= pri_field_d;
         primary_damp_x10_q            <= pri_df;
         primary_peak_cdb_q            <= pri_gp;
         primary_lowrate_analog_gain_q <= pri_gain_d;
         primary_gain_apply_q          <= pri_apply_d;
      end
   end

   // secondary loop settings; its bandwidth code comes from outside the bank
   // and reaches the damping decode in the same edge as the register fields
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         secondary_damping_field_q       <= lbdc_pkg::DAMP_C3;
         secondary_damp_x10_q            <= lbdc_pkg::DF_5;
         secondary_peak_cdb_q            <= lbdc_pkg::GP_0P1;
         secondary_lowrate_analog_gain_q <=
            lbdc_pkg::RST_SEC_DAMPING[lbdc_pkg::GAIN_MSB:lbdc_pkg::GAIN_LSB];
         secondary_gain_apply_q          <= 1'b0;
      end else begin
         secondary_damping_field_q       <= sec_field_d;
         secondary_damp_x10_q            <= sec_df;
         secondary_peak_cdb_q            <= sec_gp;
         secondary_lowrate_analog_gain_q <= sec_gain_d;
         secondary_gain_apply_q          <= sec_apply_d;
      end
   end
endmodule

/* File: verilog/lbdc_pkg.sv */
// constants for the loop bandwidth and damping configuration bank
package lbdc_pkg;
   // register addresses on the serial configuration port
   localparam logic [6:0] ADDR_PRI_LOCKED_BW = 7'h67;
   localparam logic [6:0] ADDR_PRI_ACQ_BW    = 7'h69;
   localparam logic [6:0] ADDR_SEC_DAMPING   = 7'h6A;
   localparam logic [6:0] ADDR_PRI_DAMPING   = 7'h6B;
   // reset values
   localparam logic [7:0] RST_PRI_LOCKED_BW  = 8'h10;
   localparam logic [7:0] RST_PRI_ACQ_BW     = 8'h11;
   localparam logic [7:0] RST_SEC_DAMPING    = 8'h13;
   localparam logic [7:0] RST_PRI_DAMPING    = 8'h13;
   localparam logic [7:0] RDATA_NONE         = 8'h00;
   // field positions
   localparam int LOCKED_BW_MSB = 1;
   localparam int ACQ_BW_MSB    = 3;
   localparam int DAMP_MSB      = 2;
   localparam int GAIN_MSB      = 6;
   localparam int GAIN_LSB      = 4;
   // bandwidth codes
   localparam logic [1:0] BW_18HZ = 2'h0;
   localparam logic [1:0] BW_35HZ = 2'h1;
   localparam logic [1:0] BW_70HZ = 2'h2;
   // damping codes
   localparam logic [2:0] DAMP_C1 = 3'h1;
   localparam logic [2:0] DAMP_C2 = 3'h2;
   localparam logic [2:0] DAMP_C3 = 3'h3;
   localparam logic [2:0] DAMP_C4 = 3'h4;
   localparam logic [2:0] DAMP_C5 = 3'h5;
   // damping factor in tenths
   localparam logic [7:0] DF_1P2  = 8'h0C;
   localparam logic [7:0] DF_2P5  = 8'h19;
   localparam logic [7:0] DF_5    = 8'h32;
   localparam logic [7:0] DF_10   = 8'h64;
   localparam logic [7:0] DF_20   = 8'hC8;
   localparam logic [7:0] DF_NONE = 8'h00;
   // gain peak in hundredths of a dB
   localparam logic [5:0] GP_0P4  = 6'h28;
   localparam logic [5:0] GP_0P2  = 6'h14;
   localparam logic [5:0] GP_0P1  = 6'h0A;
   localparam logic [5:0] GP_0P06 = 6'h06;
   localparam logic [5:0] GP_0P03 = 6'h03;
   localparam logic [5:0] GP_NONE = 6'h00;
endpackage
